/* logic/sbc_commutation_ctrl.sv */
// Sensorless three-phase BLDC commutation controller core
`timescale 1ns/100ps
`include "sbc_map.svh"

module sbc_commutation_ctrl
#(
   parameter int STOP_CYCLES = `SBC_STOP_TIME_US * `SBC_CLK_MHZ,
   parameter int LOCK_CYCLES = `SBC_LOCK_TIME_US * `SBC_CLK_MHZ
)
(
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic ce,
   input  wire logic pwmIn,
   input  wire logic positionIn,
   input  wire logic overcurrentIn,
   input  wire logic rotationDirectionIn,
   input  wire logic leadSelLo,
   input  wire logic leadSelHi,
   input  wire logic startWidthSelA,
   input  wire logic startWidthSelB,
   input  wire logic outputFormSel,
   input  wire logic overlapSel,
   output wire logic uHighOnN,
   output wire logic vHighOnN,
   output wire logic wHighOnN,
   output wire logic uLowOn,
   output wire logic vLowOn,
   output wire logic wLowOn,
   output wire logic rotationSignalOut
);

   localparam sbc_pkg::sbc_cnt_t STOP_CNT = sbc_pkg::sbc_cnt_t'(STOP_CYCLES);
   localparam sbc_pkg::sbc_cnt_t LOCK_CNT = sbc_pkg::sbc_cnt_t'(LOCK_CYCLES);

   // Pattern per step: {high W V U, low W V U}
   function automatic sbc_pkg::sbc_pat_t patOf(input sbc_pkg::sbc_step_t s);
      sbc_pkg::sbc_pat_t p;
      case (s)
         3'h0:    p = 6'h0a;
         3'h1:    p = 6'h0c;
         3'h2:    p = 6'h14;
         3'h3:    p = 6'h11;
         3'h4:    p = 6'h21;
         3'h5:    p = 6'h22;
         default: p = 6'h00;
      endcase
      return p;
   endfunction : patOf

   // Next step in the chosen direction
   function automatic sbc_pkg::sbc_step_t nextStep(input sbc_pkg::sbc_step_t s,
                                                   input logic rev);
      sbc_pkg::sbc_step_t n;
      if (rev)
         n = (s == `SBC_STEP_FIRST) ? `SBC_STEP_LAST : s - 3'h1;
      else
         n = (s == `SBC_STEP_LAST) ? `SBC_STEP_FIRST : s + 3'h1;
      return n;
   endfunction : nextStep

   logic [`SBC_IN_W-1:0]   syncA_q;
   logic [`SBC_IN_W-1:0]   syncB_q;
   logic [`SBC_IN_W-1:0]   syncAD;
   logic [`SBC_IN_W-1:0]   syncBD;

   // Every pin but mclk, resetn and ce passes two flip-flops before use
   always_comb
   begin
      syncAD = {overlapSel, outputFormSel, startWidthSelB, startWidthSelA, leadSelHi,
                leadSelLo, rotationDirectionIn, overcurrentIn, positionIn, pwmIn};
      syncBD = syncA_q;
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         syncA_q <= `SBC_SYNC_RST; // PWM off level, so no false fall follows reset
         syncB_q <= `SBC_SYNC_RST;
      end
      else if (ce)
      begin
         syncA_q <= syncAD;
         syncB_q <= syncBD;
      end
   end

   logic                   pwmS;
   logic                   posS;
   logic                   ocS;
   logic                   dirS;
   logic [1:0]             leadS;
   logic                   formS;
   logic                   lapS;

   assign pwmS  = syncB_q[`SBC_I_PWM];
   assign posS  = syncB_q[`SBC_I_POS];
   assign ocS   = syncB_q[`SBC_I_OC];
   assign dirS  = syncB_q[`SBC_I_DIR];
   assign leadS = {syncB_q[`SBC_I_LEADHI], syncB_q[`SBC_I_LEADLO]};
   assign formS = syncB_q[`SBC_I_FORM];
   assign lapS  = syncB_q[`SBC_I_LAP];

   sbc_pkg::sbc_state_e    state_q,    stateD;
   sbc_pkg::sbc_step_t     step_q,     stepD;
   sbc_pkg::sbc_cnt_t      fTimer_q,   fTimerD;
   logic                   first_q,    firstD;
   sbc_pkg::sbc_cnt_t      idle_q,     idleD;
   logic [1:0]             pulse_q,    pulseD;
   logic                   pwmPrev_q,  pwmPrevD;
   logic                   posSmp_q,   posSmpD;
   logic                   posLvl_q,   posLvlD;
   logic [3:0]             cross_q,    crossD;
   logic [1:0]             mod3_q,     mod3D;
   logic                   uRes_q,     uResD;
   logic                   fgEn_q,     fgEnD;
   sbc_pkg::sbc_cnt_t      period_q,   periodD;
   sbc_pkg::sbc_cnt_t      delay_q,    delayD;
   logic                   armed_q,    armedD;
   sbc_pkg::sbc_cnt_t      lapLen_q,   lapLenD;
   sbc_pkg::sbc_cnt_t      lap_q,      lapD;
   sbc_pkg::sbc_pat_t      prevPat_q,  prevPatD;
   logic [2:0]             hiN_q,      hiND;
   logic [2:0]             lo_q,       loD;
   logic                   fg_q,       fgD;

   logic [4:0]             widthBits;
   logic [20:0]            limWide;
   sbc_pkg::sbc_cnt_t      lim;
   sbc_pkg::sbc_cnt_t      curLim;
   logic                   stopSeen;
   logic                   pwmFall;
   logic                   crossing;
   logic                   lead30;
   sbc_pkg::sbc_pat_t      pat;
   logic                   gateHi;
   logic                   chop;
   logic [2:0]             hiOn;
   logic [2:0]             loOn;

   // Sequencer: start/stop, forced and sensed commutation, lap, rotation signal
   always_comb
   begin
      stateD   = state_q;
      stepD    = step_q;
      fTimerD  = fTimer_q;
      firstD   = first_q;
      pulseD   = pulse_q;
      crossD   = cross_q;
      mod3D    = mod3_q;
      uResD    = uRes_q;
      fgEnD    = fgEn_q;
      periodD  = period_q;
      delayD   = delay_q;
      armedD   = armed_q;
      lapLenD  = lapLen_q;
      lapD     = lap_q;
      prevPatD = prevPat_q;
      posSmpD  = posSmp_q;
      posLvlD  = posLvl_q;
      pwmPrevD = pwmS;
      crossing = 1'b0;
      lead30   = (leadS == `SBC_LEAD_30);
      // Start-up counter width from the select pair
      case ({syncB_q[`SBC_I_WIDB], syncB_q[`SBC_I_WIDA]})
         2'h3:    widthBits = `SBC_BITS_16;
         2'h2:    widthBits = `SBC_BITS_14;
         default: widthBits = `SBC_BITS_12;
      endcase
      // Six steps of 2^(bits+3) clocks each make one electrical turn
      limWide = (21'h1 << (widthBits + `SBC_BIT_EXTRA)) - 21'h1;
      lim     = limWide[19:0];
      // Thirty degree forced lead: first step cut to half length
      curLim  = (first_q && lead30) ? (lim >> 1) : lim;
      // PWM held high (duty zero) for the stop time is a stop
      idleD    = !pwmS ? '0 : ((idle_q == STOP_CNT) ? idle_q : idle_q + 20'h1);
      stopSeen = (idle_q == STOP_CNT);
      pwmFall  = pwmPrev_q & ~pwmS;
      // Position sampled only at PWM falling edges, confirmed on two in a row
      if (pwmFall)
      begin
         posSmpD = posS;
         if ((posS == posSmp_q) && (posS != posLvl_q))
         begin
            crossing = 1'b1;
            posLvlD  = posS;
         end
      end
      case (state_q)
         sbc_pkg::SBC_IDLE:
         begin
            fgEnD = 1'b0;
            if (pwmFall && (pulse_q != `SBC_START_PULSES))
               pulseD = pulse_q + 2'h1;
            if (stopSeen)
               pulseD = '0;
            if (pulse_q == `SBC_START_PULSES)
            begin
               stateD  = sbc_pkg::SBC_FORCE;
               stepD   = `SBC_STEP_FIRST;
               fTimerD = '0;
               firstD  = 1'b1;
               crossD  = '0;
               pulseD  = '0;
               lapD    = '0;
               armedD  = 1'b0;
            end
         end
         sbc_pkg::SBC_FORCE:
         begin
            fgEnD = 1'b0;
            if (fTimer_q >= curLim)
            begin
               fTimerD = '0;
               firstD  = 1'b0;
               stepD   = nextStep(step_q, dirS);
            end
            else
               fTimerD = fTimer_q + 20'h1;
            if (crossing)
               crossD = cross_q + 4'h1;
            if (cross_q == `SBC_CROSS_RUN)
            begin
               stateD  = sbc_pkg::SBC_RUN;
               periodD = '0;
               armedD  = 1'b0;
               crossD  = '0;
               mod3D   = '0;
               uResD   = posLvl_q;
            end
            if (stopSeen)
               stateD = sbc_pkg::SBC_IDLE;
         end
         sbc_pkg::SBC_RUN:
         begin
            periodD = (period_q == LOCK_CNT) ? period_q : period_q + 20'h1;
            if (lap_q != '0)
               lapD = lap_q - 20'h1;
            // Commutate when the delay after the crossing runs out
            if (armed_q)
            begin
               if (delay_q == '0)
               begin
                  armedD   = 1'b0;
                  prevPatD = patOf(step_q);
                  stepD    = nextStep(step_q, dirS);
                  lapD     = lapS ? '0 : lapLen_q;
               end
               else
                  delayD = delay_q - 20'h1;
            end
            if (crossing)
            begin
               periodD = '0;
               armedD  = 1'b1;
               // Delay is 30 degrees less the lead, as part of the 60 degree interval
               case (leadS)
                  `SBC_LEAD_0:   delayD = period_q >> 1;
                  `SBC_LEAD_7P5: delayD = (period_q >> 2) + (period_q >> 3);
                  `SBC_LEAD_15:  delayD = period_q >> 2;
                  default:       delayD = '0;
               endcase
               // Overlap shrinks as the lead grows
               case (leadS)
                  `SBC_LEAD_0,
                  `SBC_LEAD_7P5: lapLenD = period_q >> 3;
                  default:       lapLenD = period_q >> 4;
               endcase
               if (cross_q != `SBC_CROSS_FG)
                  crossD = cross_q + 4'h1;
               if (cross_q == `SBC_CROSS_FG - 4'h1)
                  fgEnD = 1'b1;
               // U-phase result flips every third crossing
               if (mod3_q == `SBC_U_CROSSES)
               begin
                  mod3D = '0;
                  uResD = ~uRes_q;
               end
               else
                  mod3D = mod3_q + 2'h1;
            end
            if (period_q == LOCK_CNT)
            begin
               stateD  = sbc_pkg::SBC_FORCE;
               stepD   = `SBC_STEP_FIRST;
               fTimerD = '0;
               firstD  = 1'b1;
               crossD  = '0;
               fgEnD   = 1'b0;
               armedD  = 1'b0;
               lapD    = '0;
            end
            if (stopSeen)
            begin
               stateD = sbc_pkg::SBC_IDLE;
               fgEnD  = 1'b0;
            end
         end
         default:
         begin
            stateD = sbc_pkg::SBC_IDLE;
         end
      endcase
      // Phase pattern plus the outgoing pair while the lap window is open
      pat    = patOf(step_q) | ((lap_q != '0) ? prevPat_q : 6'h00);
      gateHi = formS ? ~step_q[0] : 1'b1;
      chop   = ~pwmS & ~ocS;
      if (state_q == sbc_pkg::SBC_IDLE)
      begin
         hiOn = 3'h0;
         loOn = 3'h0;
      end
      else
      begin
         hiOn = pat[5:3] & (gateHi ? {3{chop}} : 3'h7);
         loOn = pat[2:0] & (gateHi ? 3'h7 : {3{chop}});
      end
      hiND = ~hiOn;
      loD  = loOn;
      fgD  = (state_q == sbc_pkg::SBC_RUN) & fgEn_q & uRes_q;
   end

   // Register the sequencer state
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         state_q   <= sbc_pkg::SBC_IDLE;
         step_q    <= `SBC_STEP_FIRST;
         fTimer_q  <= '0;
         first_q   <= 1'b0;
         idle_q    <= '0;
         pulse_q   <= '0;
         pwmPrev_q <= 1'b1;
         posSmp_q  <= 1'b0;
         posLvl_q  <= 1'b0;
         cross_q   <= '0;
         mod3_q    <= '0;
         uRes_q    <= 1'b0;
         fgEn_q    <= 1'b0;
         period_q  <= '0;
         delay_q   <= '0;
         armed_q   <= 1'b0;
         lapLen_q  <= '0;
         lap_q     <= '0;
         prevPat_q <= '0;
         hiN_q     <= 3'h7;
         lo_q      <= 3'h0;
         fg_q      <= 1'b0;
      end
      else if (ce)
      begin
         state_q   <= stateD;
         step_q    <= stepD;
         fTimer_q  <= fTimerD;
         first_q   <= firstD;
         idle_q    <= idleD;
         pulse_q   <= pulseD;
         pwmPrev_q <= pwmPrevD;
         posSmp_q  <= posSmpD;
         posLvl_q  <= posLvlD;
         cross_q   <= crossD;
         mod3_q    <= mod3D;
         uRes_q    <= uResD;
         fgEn_q    <= fgEnD;
         period_q  <= periodD;
         delay_q   <= delayD;
         armed_q   <= armedD;
         lapLen_q  <= lapLenD;
         lap_q     <= lapD;
         prevPat_q <= prevPatD;
         hiN_q     <= hiND;
         lo_q      <= loD;
         fg_q      <= fgD;
      end
   end

   // Outputs straight from registers
   assign uHighOnN          = hiN_q[0];
   assign vHighOnN          = hiN_q[1];
   assign wHighOnN          = hiN_q[2];
   assign uLowOn            = lo_q[0];
   assign vLowOn            = lo_q[1];
   assign wLowOn            = lo_q[2];
   assign rotationSignalOut = fg_q;

endmodule : sbc_commutation_ctrl

/* logic/sbc_map.svh */
// Constants for the sensorless BLDC commutation controller
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
// Clock rate and the times derived from it
`define SBC_CLK_MHZ        100
`define SBC_STOP_TIME_US   1000
`define SBC_LOCK_TIME_US   10000
// Synchronised pin positions
`define SBC_IN_W           10
`define SBC_I_PWM          0
`define SBC_I_POS          1
`define SBC_I_OC           2
`define SBC_I_DIR          3
`define SBC_I_LEADLO       4
`define SBC_I_LEADHI       5
`define SBC_I_WIDA         6
`define SBC_I_WIDB         7
`define SBC_I_FORM         8
`define SBC_I_LAP          9
// Synchroniser reset: PWM pin idles high (off), the rest low
`define SBC_SYNC_RST       10'h001
// Start-up counter widths
`define SBC_BITS_16        5'h10
`define SBC_BITS_14        5'h0e
`define SBC_BITS_12        5'h0c
`define SBC_BIT_EXTRA      5'h03
// Lead angle codes {hi, lo}
`define SBC_LEAD_0         2'h0
`define SBC_LEAD_7P5       2'h1
`define SBC_LEAD_15        2'h2
`define SBC_LEAD_30        2'h3
// Sequencing counts
`define SBC_STEP_FIRST     3'h0
`define SBC_STEP_LAST      3'h5
`define SBC_START_PULSES   2'h2
`define SBC_CROSS_RUN      4'h2
`define SBC_CROSS_FG       4'h8
`define SBC_U_CROSSES      2'h2
`endif

/* logic/sbc_pkg.sv */
// Types for the sensorless BLDC commutation controller
package sbc_pkg;
   typedef enum logic [2:0] {
      SBC_IDLE  = 3'h1,
      SBC_FORCE = 3'h2,
      SBC_RUN   = 3'h4
   } sbc_state_e;
   typedef logic [19:0] sbc_cnt_t;
   typedef logic [2:0]  sbc_step_t;
   typedef logic [5:0]  sbc_pat_t;
endpackage : sbc_pkg

/* verif/sbc_chk.sv */
// Port checker for the commutation controller
`timescale 1ns/100ps
module sbc_chk
#(
   parameter int STOP_CYCLES = 200
)
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic pwmIn,
   input wire logic overcurrentIn,
   input wire logic outputFormSel,
   input wire logic overlapSel,
   input wire logic uHighOnN,
   input wire logic vHighOnN,
   input wire logic wHighOnN,
   input wire logic uLowOn,
   input wire logic vLowOn,
   input wire logic wLowOn,
   input wire logic rotationSignalOut
);
   localparam int StopMargin = 6;
   logic [19:0] hiCnt_q;
   logic [19:0] hiCnt_d;
   logic [2:0]  hiOn;
   logic [2:0]  loOn;
   logic        allOff;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Output masks, one bit a phase
   assign hiOn = ~{wHighOnN, vHighOnN, uHighOnN};
   assign loOn = {wLowOn, vLowOn, uLowOn};
   assign allOff = (hiOn == 3'h0) && (loOn == 3'h0);
   // Count cycles with the PWM input held off
   always_comb
   begin
      hiCnt_d = pwmIn ? hiCnt_q + 20'h1 : 20'h0;
      if (hiCnt_q == 20'hfffff)
         hiCnt_d = hiCnt_q;
   end
   always_ff @(posedge mclk)
   begin
      hiCnt_q <= resetn ? hiCnt_d : 20'h0;
   end
   a_reset_off: assert property (disable iff (1'b0) !resetn |=> allOff && !rotationSignalOut)
      else $error("outputs active after reset");
   a_high_needs_pwm: assert property ((hiOn != 3'h0) && !$past(outputFormSel, 3)
      |-> !$past(pwmIn, 3) && !$past(overcurrentIn, 3))
      else $error("upper output on without PWM on");
   a_oc_cuts_high: assert property ($past(overcurrentIn, 3) && !$past(outputFormSel, 3)
      |-> hiOn == 3'h0)
      else $error("upper output on during overcurrent");
   a_no_shoot: assert property ((hiOn & loOn) == 3'h0)
      else $error("upper and lower of one phase on");
   a_plain_single: assert property (overlapSel && $past(overlapSel, 4)
      |-> $onehot0(hiOn) && $onehot0(loOn))
      else $error("two phases on without overlap");
   a_fg_low_idle: assert property (allOff |-> !rotationSignalOut)
      else $error("rotation signal high while stopped");
   a_stop_off: assert property (hiCnt_q == STOP_CYCLES + StopMargin |-> allOff)
      else $error("drive still on after stop");
   a_first_step: assert property ($past(allOff) && !allOff |-> loOn == 3'h2)
      else $error("start pattern wrong");
   cover property ($past(allOff) && !allOff);
   cover property (hiCnt_q == STOP_CYCLES + StopMargin);
   cover property (overcurrentIn && loOn != 3'h0);
endmodule : sbc_chk
bind sbc_commutation_ctrl sbc_chk #(.STOP_CYCLES(STOP_CYCLES)) i_sbc_chk (
   .mclk(mclk), .resetn(resetn), .pwmIn(pwmIn), .overcurrentIn(overcurrentIn),
   .outputFormSel(outputFormSel), .overlapSel(overlapSel), .uHighOnN(uHighOnN),
   .vHighOnN(vHighOnN), .wHighOnN(wHighOnN), .uLowOn(uLowOn), .vLowOn(vLowOn),
   .wLowOn(wLowOn), .rotationSignalOut(rotationSignalOut));

/* verif/sbc_commutation_ctrl_test.sv */
// Testbench for the commutation controller
`timescale 1ns/100ps
module sbc_commutation_ctrl_test;
   localparam int StopCyc = 200;
   logic mclk          = 1'b0;
   logic resetn        = 1'b0;
   logic runPwm        = 1'b0;
   logic overcurrentIn = 1'b0;
   logic dirIn         = 1'b0;
   logic leadLo        = 1'b0;
   logic leadHi        = 1'b0;
   logic formSel       = 1'b0;
   logic lapSel        = 1'b1;
   logic pwmIn, positionIn, fg;
   logic uH, vH, wH, uL, vL, wL;
   int   num_errors = 0;
   int   checked = 0;
   int   seedVal;
   // Free-running clock
   always #5 mclk = ~mclk;
   sbc_commutation_ctrl #(.STOP_CYCLES(StopCyc), .LOCK_CYCLES(2000)) i_sbc_commutation_ctrl (
      .mclk(mclk), .resetn(resetn), .ce(1'b1), .pwmIn(pwmIn), .positionIn(positionIn),
      .overcurrentIn(overcurrentIn), .rotationDirectionIn(dirIn), .leadSelLo(leadLo),
      .leadSelHi(leadHi), .startWidthSelA(1'b1), .startWidthSelB(1'b0),
      .outputFormSel(formSel), .overlapSel(lapSel), .uHighOnN(uH), .vHighOnN(vH),
      .wHighOnN(wH), .uLowOn(uL), .vLowOn(vL), .wLowOn(wL), .rotationSignalOut(fg));
   sbc_host_model i_sbc_host_model (
      .mclk(mclk), .runPwm(runPwm), .hiOnN({wH, vH, uH}), .loOn({wL, vL, uL}),
      .pwmIn(pwmIn), .positionIn(positionIn));
   // Expected upper and lower masks {w, v, u} of a step
   function automatic logic [7:0] step_mask(input int s);
      case (s)
         0: return 8'h12;
         1: return 8'h14;
         2: return 8'h24;
         3: return 8'h21;
         4: return 8'h41;
         default: return 8'h42;
      endcase
   endfunction : step_mask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict
   // Gather which outputs were on during a window, {upper, lower}
   task automatic observe(input int n, output logic [7:0] m);
      m = 8'h0;
      repeat (n)
      begin
         @(negedge mclk);
         m = m | {1'b0, ~{wH, vH, uH}, 1'b0, wL, vL, uL};
      end
   endtask : observe
   // Main sequence
   initial
   begin
      logic [7:0] m;
      int         len;
      int         i;
      seedVal = $urandom(32'h812f6629);
      repeat (6) @(negedge mclk);
      resetn = 1'b1;
      observe(4, m);
      check("idle outputs", m, 8'h00);
      check("idle rotation", {7'h0, fg}, 8'h00);
      $display("test reset done");
      for (int t = 0; t < 2; t++)
      begin
         dirIn = t[0];
         {leadHi, leadLo} = t ? 2'h3 : 2'($urandom_range(2, 0));
         formSel = 1'($urandom);
         len = t ? 16384 : 32768;
         runPwm = 1'b1;
         i = 0;
         while (vL !== 1'b1 && i < 500)
         begin
            @(negedge mclk);
            i++;
         end
         observe(40, m);
         check("first step", m, step_mask(0));
         check("forced rotation", {7'h0, fg}, 8'h00);
         repeat (len - 300) @(negedge mclk);
         observe(40, m);
         check("step held", m, step_mask(0));
         repeat (300) @(negedge mclk);
         observe(40, m);
         check("second step", m, step_mask(t ? 5 : 1));
         formSel = 1'b0;
         overcurrentIn = 1'b1;
         repeat (5) @(negedge mclk);
         observe(40, m);
         check("overcurrent", m, step_mask(t ? 5 : 1) & 8'h0f);
         overcurrentIn = 1'b0;
         runPwm = 1'b0;
         repeat (StopCyc + 20) @(negedge mclk);
         observe(5, m);
         check("stopped", {m[7:1], fg}, 8'h00);
         $display("test start and stop %0d done", t);
      end
      give_verdict();
   end
   // Watchdog against a hang
   initial
   begin
      repeat (70000) @(posedge mclk);
      num_errors++;
      give_verdict();
   end
endmodule : sbc_commutation_ctrl_test

/* verif/sbc_host_model.sv */
// Host model: PWM source and phase majority feedback
`timescale 1ns/100ps
module sbc_host_model
(
   input  wire logic       mclk,
   input  wire logic       runPwm,
   input  wire logic [2:0] hiOnN,
   input  wire logic [2:0] loOn,
   output wire logic       pwmIn,
   output wire logic       positionIn
);
   logic [4:0] cnt_q = 5'h0;
   logic       flt_q = 1'b0;
   logic [2:0] ph;
   // PWM period of 20 cycles, 14 of them on, changed off the sampling edge
   always_ff @(negedge mclk)
   begin
      cnt_q <= (cnt_q == 5'h13) ? 5'h0 : cnt_q + 5'h1;
      flt_q <= !flt_q;
   end
   assign pwmIn = !(runPwm && cnt_q < 5'h0e);
   // Terminal level: high side on, low side on, or a floating pattern
   assign ph = ~hiOnN | (~loOn & {3{flt_q}});
   assign positionIn = (ph[0] & ph[1]) | (ph[1] & ph[2]) | (ph[0] & ph[2]);
endmodule : sbc_host_model
